// File: verilog/rmsr_select_read.sv
// Overview of operation
// - The low byte of the event select register picks which metric the readout reports.
// - Bits 41 down to 32 of the event select register name the identifier being read.
// - Any active identifier is accepted and the field is as wide as the association identifier.
// - An unsupported identifier or event code sets the error flag, bit 63, of the readout.
// - Data not yet available for the identifier sets the unavailable flag, bit 62.
// - The 62-bit data field is meaningful only when both flags are clear.
// - No interrupt or threshold trigger exists; values are only obtained by explicit reads.
// - This register pair is independent of the general performance counters.
// - Event select and association registers may be read and written at any time.
// - A write that changes a reserved bit is rejected with a protection fault, code zero.
// - A write with an identifier above the highest identifier is rejected with a fault.
// - Association and monitoring state are unchanged across system management interrupts.
// - Deep power states may lower occupancy counts and flushing may raise bandwidth counts.
// - Event codes 01h occupancy, 02h total bandwidth, 03h local bandwidth; others reserved.
`default_nettype none
module rmsr_select_read (
  input wire logic clk, // 20 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic accWrite, // Special register write instruction strobe
  input wire logic accRead, // Special register read instruction strobe
  input wire rmsr_pkg::reg_sel_type accReg, // Register addressed
  input wire logic [rmsr_pkg::DataWidth-1:0] accWrData, // Write data
  output logic [rmsr_pkg::DataWidth-1:0] accRdData, // Read data, registered
  output logic accRdValid, // Read data valid pulse
  output logic accFault, // Protection fault pulse, error code zero
  output logic [rmsr_pkg::IdWidth-1:0] activeIdentifier, // Identifier tagging this thread
  output logic [rmsr_pkg::IdWidth-1:0] queryIdentifier, // Identifier asked of the monitor
  output logic [7:0] queryEvent, // Event code asked of the monitor
  input wire logic [rmsr_pkg::CountWidth-1:0] queryCount, // Monitor count for the query
  input wire logic queryAvailable // Monitor has data for the query
);

  function automatic logic evtSupported(input logic [7:0] code);
    logic ok;
    ok = 1'b0;
    if (code == rmsr_pkg::EvtOccupancy || code == rmsr_pkg::EvtTotalBw ||
        code == rmsr_pkg::EvtLocalBw) begin
      ok = rmsr_pkg::EvtSupportMask[code[1:0]];
    end
    return ok;
  endfunction

  rmsr_pkg::sel_type selQ;
  logic [rmsr_pkg::DataWidth-1:0] assocQ;
  logic [rmsr_pkg::DataWidth-1:0] rdDataQ;
  logic rdValidQ;
  logic faultQ;

  wire logic selAccess = (accReg == rmsr_pkg::RegEventSelect);
  wire logic assocAccess = (accReg == rmsr_pkg::RegThreadAssoc);
  wire logic ctrAccess = (accReg == rmsr_pkg::RegCounterReadout);

  // Reserved bits hold zero, so any one in the write changes a reserved bit
  wire logic [rmsr_pkg::DataWidth-1:0] writeMask =
    selAccess ? rmsr_pkg::SelWritableMask : rmsr_pkg::AssocWritableMask;
  wire logic resvTouched = |(accWrData & ~writeMask);
  wire logic [rmsr_pkg::IdWidth-1:0] writeId = selAccess ?
    accWrData[rmsr_pkg::IdMsb:rmsr_pkg::IdLsb] : accWrData[rmsr_pkg::IdWidth-1:0];
  wire logic idTooHigh = writeId > rmsr_pkg::HighestIdentifier;
  // The readout is read only; a write to it faults as well
  wire logic writeBad = accWrite && (ctrAccess || resvTouched || idTooHigh);
  wire logic writeSel = accWrite && selAccess && !writeBad;
  wire logic writeAssoc = accWrite && assocAccess && !writeBad;

  // Readout built live from the latest selection, never a stale snapshot
  wire logic selIdBad = selQ.monitoringIdentifier > rmsr_pkg::HighestIdentifier;
  wire logic selErr = selIdBad || !evtSupported(selQ.eventCodeField);
  rmsr_pkg::ctr_type ctrNow;
  assign ctrNow.error = selErr;
  assign ctrNow.unavailable = !selErr && !queryAvailable;
  // Count passed through as the monitor reports it; may fall or rise between reads
  // Count zeroed unless both flags clear, so stale data never leaks
  assign ctrNow.data = (selErr || !queryAvailable) ? '0 : queryCount;

  wire logic [rmsr_pkg::DataWidth-1:0] readMux =
    selAccess ? rmsr_pkg::DataWidth'(selQ) :
    assocAccess ? assocQ : rmsr_pkg::DataWidth'(ctrNow);

  // Only special register writes change state; no other event reaches it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selQ <= rmsr_pkg::SelResetVal;
      assocQ <= rmsr_pkg::AssocResetVal;
    end else begin
      if (writeSel) begin
        selQ <= accWrData & rmsr_pkg::SelWritableMask;
      end
      if (writeAssoc) begin
        assocQ <= accWrData & rmsr_pkg::AssocWritableMask;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataQ <= '0;
      rdValidQ <= 1'b0;
      faultQ <= 1'b0;
    end else begin
      rdValidQ <= accRead;
      faultQ <= writeBad;
      if (accRead) begin
        rdDataQ <= readMux;
      end
    end
  end

  // No interrupt output: values leave only through reads
  assign accRdData = rdDataQ;
  assign accRdValid = rdValidQ;
  assign accFault = faultQ;
  assign activeIdentifier = assocQ[rmsr_pkg::IdWidth-1:0];
  // Query path is private to this pair, separate from performance counters
  assign queryIdentifier = selQ.monitoringIdentifier;
  assign queryEvent = selQ.eventCodeField;

endmodule // rmsr_select_read
`default_nettype wire

// File: inc/rmsr_pkg.sv
`default_nettype none
package rmsr_pkg;
  localparam int unsigned DataWidth = 64;
  localparam int unsigned IdWidth = 10;
  localparam int unsigned CountWidth = 62;
  // Event selection fields
  localparam int unsigned EvtLsb = 0;
  localparam int unsigned EvtMsb = 7;
  localparam int unsigned IdLsb = 32;
  localparam int unsigned IdMsb = 41;
  // Readout flag positions
  localparam int unsigned ErrBit = 63;
  localparam int unsigned UnavailBit = 62;
  // Writable masks; every other bit is reserved and reads as zero
  localparam logic [63:0] SelWritableMask = 64'h0000_03ff_0000_00ff;
  localparam logic [63:0] AssocWritableMask = 64'h0000_0000_0000_03ff;
  localparam logic [63:0] SelResetVal = 64'h0000_0000_0000_0000;
  localparam logic [63:0] AssocResetVal = 64'h0000_0000_0000_0000;
  // Highest identifier the monitor tracks; plain default
  localparam logic [IdWidth-1:0] HighestIdentifier = 10'h3ff;
  // Event codes
  localparam logic [7:0] EvtOccupancy = 8'h01;
  localparam logic [7:0] EvtTotalBw = 8'h02;
  localparam logic [7:0] EvtLocalBw = 8'h03;
  // Supported events, bit n for code n; plain default supports all three
  localparam logic [3:0] EvtSupportMask = 4'he;

  typedef enum logic [2:0] {
    RegEventSelect = 3'b001,
    RegThreadAssoc = 3'b010,
    RegCounterReadout = 3'b100
  } reg_sel_type;

  typedef struct packed {
    logic [63:42] resvHi;
    logic [IdWidth-1:0] monitoringIdentifier;
    logic [31:8] resvLo;
    logic [7:0] eventCodeField;
  } sel_type;

  typedef struct packed {
    logic error;
    logic unavailable;
    logic [CountWidth-1:0] data;
  } ctr_type;
endpackage
`default_nettype wire

// File: bench/rmsr_select_read_monitor.sv
`default_nettype none
module rmsr_select_read_monitor (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic accWrite, // write
  input wire logic accRead, // read
  input wire rmsr_pkg::reg_sel_type accReg, // register
  input wire logic [63:0] accWrData, // wdata
  input wire logic [63:0] accRdData, // rdata
  input wire logic accRdValid, // valid
  input wire logic accFault, // fault
  input wire logic [9:0] activeIdentifier, // assoc id
  input wire logic [9:0] queryIdentifier, // query id
  input wire logic [7:0] queryEvent, // query event
  input wire logic [61:0] queryCount, // count
  input wire logic queryAvailable // has data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire selWr = accWrite && accReg == rmsr_pkg::RegEventSelect;
  wire selBad = |(accWrData & ~rmsr_pkg::SelWritableMask);
  wire asOk = ~|(accWrData & ~rmsr_pkg::AssocWritableMask);
  wire ctrRd = accRead && accReg == rmsr_pkg::RegCounterReadout;
  wire evtOk = queryEvent inside {8'h01, 8'h02, 8'h03};
  sel_write_a:
    assert property (selWr && !selBad |=> !accFault && queryEvent == $past(accWrData[7:0])
      && queryIdentifier == $past(accWrData[41:32])) else $error("select write lost");
  resv_fault_a:
    assert property (selWr && selBad |=> accFault && $stable(queryEvent)
      && $stable(queryIdentifier)) else $error("reserved write taken");
  assoc_write_a:
    assert property (accWrite && accReg == rmsr_pkg::RegThreadAssoc && asOk
      |=> activeIdentifier == $past(accWrData[9:0])) else $error("assoc write lost");
  ro_write_a:
    assert property (accWrite && accReg == rmsr_pkg::RegCounterReadout |=> accFault)
      else $error("readout write taken");
  fault_cause_a:
    assert property (!accWrite |=> !accFault) else $error("stray fault");
  read_valid_a:
    assert property (accRdValid == $past(accRead)) else $error("read valid timing");
  err_read_a:
    assert property (ctrRd && !evtOk |=> accRdData == 64'h8000_0000_0000_0000)
      else $error("error flag wrong");
  unavail_read_a:
    assert property (ctrRd && evtOk && !queryAvailable |=> accRdData[63:62] == 2'b01)
      else $error("unavailable flag wrong");
  data_read_a:
    assert property (ctrRd && evtOk && queryAvailable |=> accRdData == {2'b00,
      $past(queryCount)}) else $error("count wrong");
endmodule // rmsr_select_read_monitor
bind rmsr_select_read rmsr_select_read_monitor mon_u (.clk(clk), .rst_n(rst_n),
  .accWrite(accWrite), .accRead(accRead), .accReg(accReg), .accWrData(accWrData),
  .accRdData(accRdData), .accRdValid(accRdValid), .accFault(accFault),
  .activeIdentifier(activeIdentifier), .queryIdentifier(queryIdentifier),
  .queryEvent(queryEvent), .queryCount(queryCount), .queryAvailable(queryAvailable));
`default_nettype wire

// File: bench/rmsr_select_read_tb.sv
`default_nettype none
module rmsr_select_read_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, accWrite, accRead, accRdValid, accFault, queryAvailable, wr, bad;
  rmsr_pkg::reg_sel_type accReg;
  logic [63:0] accWrData, accRdData, selM, asM, expD, msk;
  logic [61:0] queryCount;
  logic [9:0] activeIdentifier, queryIdentifier;
  logic [7:0] queryEvent;
  int n_mismatch = 0, samples_checked = 0, seed = 32'h6fc0eeab, k;
  rmsr_select_read dut_u (.clk(clk), .rst_n(rst_n), .accWrite(accWrite), .accRead(accRead),
    .accReg(accReg), .accWrData(accWrData), .accRdData(accRdData), .accRdValid(accRdValid),
    .accFault(accFault), .activeIdentifier(activeIdentifier), .queryEvent(queryEvent),
    .queryIdentifier(queryIdentifier), .queryCount(queryCount), .queryAvailable(queryAvailable));
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    {rst_n, accWrite, accRead, accWrData, queryCount, queryAvailable, selM, asM} = '0;
    accReg = rmsr_pkg::RegEventSelect;
    repeat (16) @(posedge clk);
    @(negedge clk) rst_n = 1;
    for (int i = 0; i < 600; i++) begin
      {wr, bad} = 2'($random(seed));
      k = $unsigned($random(seed)) % 3;
      accReg = rmsr_pkg::reg_sel_type'(3'b001 << k);
      msk = k == 1 ? rmsr_pkg::AssocWritableMask : rmsr_pkg::SelWritableMask;
      accWrData = {$random(seed), $random(seed)} & (bad ? 64'hffff_ffff_ffff_ffff : msk);
      if (!bad) accWrData[7:3] = 5'h00;
      bad = k == 2 || |(accWrData & ~msk);
      queryCount = 62'({$random(seed), $random(seed)});
      queryAvailable = 1'($random(seed));
      // One access per cycle, never a select change racing a readout read
      accWrite = wr;
      accRead = !wr;
      if (k == 0) expD = selM;
      else if (k == 1) expD = asM;
      else if (!(selM[7:0] inside {8'h01, 8'h02, 8'h03})) expD = 64'h8000_0000_0000_0000;
      else if (!queryAvailable) expD = 64'h4000_0000_0000_0000;
      else expD = {2'b00, queryCount};
      @(negedge clk);
      chk("fault", 64'(wr && bad), 64'(accFault));
      chk("valid", 64'(!wr), 64'(accRdValid));
      if (!wr) chk("read", expD, accRdData);
      if (wr && !bad && k == 0) selM = accWrData;
      if (wr && !bad && k == 1) asM = accWrData;
      chk("query", 64'({selM[41:32], selM[7:0]}), 64'({queryIdentifier, queryEvent}));
      chk("assoc", asM & 64'h3ff, 64'(activeIdentifier));
    end
    accWrite = 0;
    accRead = 0;
    $display("test random_access done");
    complete_run;
  end
endmodule // rmsr_select_read_tb
`default_nettype wire
